/* rtl/vic_regs.sv */
/*
 * Register block of a 32-source vectored interrupt controller: vector readout, pending,
 * mask, fast forcing, end of service, spurious vector and debug control.
 * Assumes sources are asynchronous level pins, a rising level makes a source pending,
 * and a plain strobe bus with read data one cycle after the read strobe.
 */
`default_nettype none
// Function
// - normal vector read returns stored handler address of the winning normal candidate, which its acknowledge makes the current source.
// - normal vector read indexes vector entries 1..31 by the winning candidate's source number.
// - no normal candidate, or a service in progress, on normal vector read returns the spurious vector.
// - fast vector read returns vector entry 0.
// - no fast interrupt on fast vector read returns the spurious vector.
// - current-source status shows the source number in bits 4..0, rest zero.
// - pending view has one bit per source, 1 while pending.
// - mask view has one bit per source, 1 when enabled.
// - line status shows fast line at bit 0, normal line at bit 1.
// - enable command ones enable sources, zeros leave them alone.
// - disable command ones disable sources, zeros leave them alone.
// - clear command ones clear pending, zeros leave them alone.
// - set command ones make sources pending, zeros leave them alone.
// - any write to end of service ends the current service.
// - spurious vector is read-write and used by both vector reads.
// - debug control bit 0 turns protection on and off.
// - debug control bit 1 holds both request lines inactive.
// - fast route enable ones on bits 1..31 route sources to the fast path.
// - fast route disable ones on bits 1..31 remove fast routing.
// - global line mask never blocks the wake request.
// - fast route status shows per source whether fast routing is on.
module vic_regs (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // register bus
   input wire vic_pkg::vic_bus_t busIn,
   output logic [vic_pkg::DATA_W-1:0] rdData,
   // interrupt sources (asynchronous pins)
   input wire logic [vic_pkg::NUM_SRC-1:0] srcIn,
   // core request lines, active low, and wake request
   output logic fastRequestLine_b,
   output logic normalRequestLine_b,
   output logic wakeRequest
);
   import vic_pkg::*;

   // ****************************
   // source synchronisers
   // ****************************
   logic [NUM_SRC-1:0] syncA, syncB, syncC, srcLvl;
   wire [NUM_SRC-1:0] agree = ~(syncB ^ syncC);
   wire [NUM_SRC-1:0] next_srcLvl = (syncC & agree) | (srcLvl & ~agree);
   wire [NUM_SRC-1:0] srcRise = next_srcLvl & ~srcLvl;

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         syncA <= ZERO_WORD;
         syncB <= ZERO_WORD;
         syncC <= ZERO_WORD;
         srcLvl <= ZERO_WORD;
      end else begin
         syncA <= srcIn;
         syncB <= syncA;
         syncC <= syncB;
         srcLvl <= next_srcLvl;
      end
   end

   // ****************************
   // address decode
   // ****************************
   logic [DATA_W-1:0] pending, enMask, fastRoute, spuriousVector;
   logic [1:0] debugControl;
   logic [ID_W-1:0] curId;
   vic_svc_t svcState;
   logic [DATA_W-1:0] vectorTable [NUM_SRC];

   wire [ADDR_W-1:0] a = busIn.addr;
   wire wr = busIn.wr;
   wire rd = busIn.rd;
   wire [DATA_W-1:0] wd = busIn.wdata;
   wire inVecRange = (a >= OFS_VECTOR_BASE) && (a <= OFS_VECTOR_LAST) && (a[1:0] == 2'h0);
   wire [ID_W-1:0] vecIdx = a[ID_W+1:2];
   wire enWr = wr && (a == OFS_ENABLE_COMMAND);
   wire disWr = wr && (a == OFS_DISABLE_COMMAND);
   wire clrWr = wr && (a == OFS_PENDING_CLEAR_COMMAND);
   wire setWr = wr && (a == OFS_PENDING_SET_COMMAND);
   wire eosWr = wr && (a == OFS_END_OF_SERVICE_COMMAND);
   wire spuWr = wr && (a == OFS_SPURIOUS_VECTOR);
   wire dbgWr = wr && (a == OFS_DEBUG_CONTROL);
   wire ffeWr = wr && (a == OFS_FAST_ROUTE_ENABLE);
   wire ffdWr = wr && (a == OFS_FAST_ROUTE_DISABLE);
   wire protectionEnable = debugControl[PROTECTION_ENABLE_BIT];
   wire globalLineMask = debugControl[GLOBAL_LINE_MASK_BIT];
   wire ivrRd = rd && (a == OFS_NORMAL_VECTOR_READOUT);
   wire fvrRd = rd && (a == OFS_FAST_VECTOR_READOUT);
   // under protection the reads are harmless; a write to the normal readout does the acknowledge, the fast readout has none
   wire ivrAck = protectionEnable ? (wr && (a == OFS_NORMAL_VECTOR_READOUT)) : ivrRd;
   wire fvrAck = fvrRd && !protectionEnable;

   // ****************************
   // arbitration
   // ****************************
   // normal candidates: enabled, pending, not fast routed; lowest number wins
   wire [DATA_W-1:0] fastSet = fastRoute | FAST_SOURCE_MASK;
   wire [DATA_W-1:0] normCand = pending & enMask & ~fastSet;
   wire fastActive = |(pending & enMask & fastSet);
   logic candValid;
   logic [ID_W-1:0] candId;

   always_comb begin
      candValid = 1'b0;
      candId = '0;
      for (int i = NUM_SRC - 1; i >= 1; i--) begin
         if (normCand[i]) begin
            candValid = 1'b1;
            candId = ID_W'(i);
         end
      end
   end

   wire svcBusy = (svcState == SVC_BUSY);
   wire normalActive = candValid && !svcBusy;
   wire takeService = ivrAck && normalActive;

   // ****************************
   // pending, mask and fast routing
   // ****************************
   wire [DATA_W-1:0] wrOnes = wd;
   wire [DATA_W-1:0] routeBits = wd & ~FAST_SOURCE_MASK;
   wire [DATA_W-1:0] ackClear = (takeService ? (FAST_SOURCE_MASK << candId) : ZERO_WORD)
                              | (fvrAck ? FAST_SOURCE_MASK : ZERO_WORD);
   wire [DATA_W-1:0] setBits = srcRise | (setWr ? wrOnes : ZERO_WORD);
   wire [DATA_W-1:0] clrBits = (clrWr ? wrOnes : ZERO_WORD) | ackClear;
   // a set in the same cycle as a clear wins
   wire [DATA_W-1:0] next_pending = (pending & ~clrBits) | setBits;
   wire [DATA_W-1:0] next_enMask = enWr ? (enMask | wrOnes)
                                 : disWr ? (enMask & ~wrOnes) : enMask;
   wire [DATA_W-1:0] next_fastRoute = ffeWr ? (fastRoute | routeBits)
                                    : ffdWr ? (fastRoute & ~routeBits) : fastRoute;

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         pending <= ZERO_WORD;
         enMask <= ZERO_WORD;
         fastRoute <= ZERO_WORD;
      end else begin
         pending <= next_pending;
         enMask <= next_enMask;
         fastRoute <= next_fastRoute;
      end
   end

   // ****************************
   // vector table and control registers
   // ****************************
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         for (int i = 0; i < NUM_SRC; i++) begin
            vectorTable[i] <= ZERO_WORD;
         end
      end else if (wr && inVecRange) begin
         vectorTable[vecIdx] <= wd;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         spuriousVector <= ZERO_WORD;
         debugControl <= DEBUG_CONTROL_RESET;
      end else begin
         if (spuWr) begin
            spuriousVector <= wd;
         end
         if (dbgWr) begin
            debugControl <= wd[1:0];
         end
      end
   end

   // ****************************
   // service state
   // ****************************
   logic [1:0] next_svcState;
   always_comb begin
      case (svcState)
         SVC_IDLE: next_svcState = takeService ? SVC_BUSY : SVC_IDLE;
         SVC_BUSY: next_svcState = eosWr ? SVC_IDLE : SVC_BUSY;
         default: next_svcState = SVC_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         svcState <= SVC_IDLE;
         curId <= '0;
      end else begin
         svcState <= vic_svc_t'(next_svcState);
         if (takeService) begin
            curId <= candId;
         end
      end
   end

   // ****************************
   // read data
   // ****************************
   wire [DATA_W-1:0] normVec = normalActive ? vectorTable[candId]
                                            : spuriousVector;
   wire [DATA_W-1:0] fastVec = fastActive ? vectorTable[0] : spuriousVector;
   wire [DATA_W-1:0] lineWord = {30'h0, !normalRequestLine_b, !fastRequestLine_b};
   wire [DATA_W-1:0] rdValue =
      inVecRange ? vectorTable[vecIdx] :
      (a == OFS_NORMAL_VECTOR_READOUT) ? normVec :
      (a == OFS_FAST_VECTOR_READOUT) ? fastVec :
      (a == OFS_CURRENT_SOURCE_STATUS) ? {27'h0, curId} :
      (a == OFS_PENDING_VIEW) ? pending :
      (a == OFS_ENABLE_MASK_VIEW) ? enMask :
      (a == OFS_CORE_LINE_STATUS) ? lineWord :
      (a == OFS_SPURIOUS_VECTOR) ? spuriousVector :
      (a == OFS_DEBUG_CONTROL) ? {30'h0, debugControl} :
      (a == OFS_FAST_ROUTE_STATUS) ? fastRoute : ZERO_WORD;

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         rdData <= ZERO_WORD;
      end else if (rd) begin
         rdData <= rdValue;
      end else begin
         rdData <= ZERO_WORD;
      end
   end

   // ****************************
   // core request lines and wake
   // ****************************
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         fastRequestLine_b <= 1'b1;
         normalRequestLine_b <= 1'b1;
         wakeRequest <= 1'b0;
      end else begin
         fastRequestLine_b <= !(fastActive && !globalLineMask);
         normalRequestLine_b <= !(normalActive && !globalLineMask);
         wakeRequest <= |(pending & enMask);
      end
   end

   // ****************************
   // checks
   // ****************************
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);

   spur_vector_a: assert property (
      ivrRd && !normalActive |=> rdData == $past(spuriousVector))
      else $error("normal vector read without source did not give spurious vector");
   norm_vector_a: assert property (
      ivrRd && normalActive |=> rdData == $past(vectorTable[candId]))
      else $error("normal vector read gave wrong entry");
   fast_vector_a: assert property (
      fvrRd |=> rdData == ($past(fastActive) ? $past(vectorTable[0])
                                             : $past(spuriousVector)))
      else $error("fast vector read gave wrong value");
   status_id_a: assert property (
      rd && a == OFS_CURRENT_SOURCE_STATUS |=> rdData[31:5] == 27'h0
                                               && rdData[4:0] == $past(curId))
      else $error("current source status malformed");
   enable_cmd_a: assert property (
      enWr |=> enMask == ($past(enMask) | $past(wd)))
      else $error("enable command mismatch");
   disable_cmd_a: assert property (
      disWr |=> enMask == ($past(enMask) & ~$past(wd)))
      else $error("disable command mismatch");
   set_pend_a: assert property (
      setWr |=> (pending & $past(wd)) == $past(wd))
      else $error("set command did not make sources pending");
   eos_idle_a: assert property (
      eosWr |=> svcState == SVC_IDLE
         ##1 normalRequestLine_b == !($past(normalActive) && !$past(globalLineMask)))
      else $error("end of service did not release service");
   mask_lines_a: assert property (
      globalLineMask && $past(globalLineMask) |-> fastRequestLine_b && normalRequestLine_b)
      else $error("request line active under global mask");
   guard_read_a: assert property (
      protectionEnable && ivrRd && !wr |=> $stable(curId) && $stable(svcState))
      else $error("protected vector read changed state");
   wake_mask_a: assert property (
      |(pending & enMask) |=> wakeRequest)
      else $error("wake request missing");
   route_bit0_a: assert property (
      ffeWr |=> !fastRoute[0] && ((fastRoute & $past(routeBits)) == $past(routeBits)))
      else $error("fast route enable mismatch");

   // ****************************
   // command and pin checks
   // ****************************
   clear_cmd_a: assert property (
      clrWr |=> (pending & $past(wd) & ~$past(setBits)) == ZERO_WORD)
      else $error("clear command left a source pending");
   mask_keep_a: assert property (
      enWr |=> (enMask & ~$past(wd)) == ($past(enMask) & ~$past(wd)))
      else $error("enable command touched a source written as zero");
   disable_keep_a: assert property (
      disWr |=> (enMask & ~$past(wd)) == ($past(enMask) & ~$past(wd)))
      else $error("disable command touched a source written as zero");
   route_off_a: assert property (
      ffdWr |=> (fastRoute & $past(routeBits)) == ZERO_WORD)
      else $error("fast route disable mismatch");
   route_keep_a: assert property (
      ffeWr |=> (fastRoute & ~$past(routeBits)) == ($past(fastRoute) & ~$past(routeBits)))
      else $error("fast route enable touched another source");
   spur_write_a: assert property (
      spuWr |=> spuriousVector == $past(wd))
      else $error("spurious vector write lost");
   guard_bit_a: assert property (
      dbgWr |=> protectionEnable == $past(wd[PROTECTION_ENABLE_BIT]))
      else $error("protection bit write lost");
   pin_rise_a: assert property (
      (|srcRise) |=> (pending & $past(srcRise)) == $past(srcRise))
      else $error("pin rise did not make the source pending");

   // ****************************
   // service and line checks
   // ****************************
   svc_take_a: assert property (
      takeService |=> curId == $past(candId) && svcState == SVC_BUSY)
      else $error("acknowledge did not record the source");
   eos_only_a: assert property (
      svcBusy && !eosWr |=> svcBusy)
      else $error("service ended without end of service write");
   busy_line_a: assert property (
      $past(svcBusy) |-> normalRequestLine_b)
      else $error("normal line active while in service");
   fast_ack_a: assert property (
      fvrAck && !setBits[0] |=> !pending[0])
      else $error("fast vector read left fast source pending");
   guard_fast_a: assert property (
      protectionEnable && fvrRd |=> pending[0] == $past(pending[0] || setBits[0]))
      else $error("protected fast vector read changed pending");
   fast_line_a: assert property (
      fastActive && !globalLineMask |=> !fastRequestLine_b)
      else $error("fast line not driven");
   norm_line_a: assert property (
      normalActive && !globalLineMask |=> !normalRequestLine_b)
      else $error("normal line not driven");
   wake_off_a: assert property (
      !(|(pending & enMask)) |=> !wakeRequest)
      else $error("wake request without enabled pending source");

   // ****************************
   // readout checks
   // ****************************
   vec_entry_a: assert property (
      rd && inVecRange |=> rdData == $past(vectorTable[vecIdx]))
      else $error("vector entry readback mismatch");
   pend_view_a: assert property (
      rd && a == OFS_PENDING_VIEW |=> rdData == $past(pending))
      else $error("pending view mismatch");
   mask_view_a: assert property (
      rd && a == OFS_ENABLE_MASK_VIEW |=> rdData == $past(enMask))
      else $error("mask view mismatch");
   line_view_a: assert property (
      rd && a == OFS_CORE_LINE_STATUS |=> rdData[31:2] == 30'h0
         && rdData[NORMAL_LINE_STATUS_BIT] == !$past(normalRequestLine_b)
         && rdData[FAST_LINE_STATUS_BIT] == !$past(fastRequestLine_b))
      else $error("line status mismatch");
   spur_view_a: assert property (
      rd && a == OFS_SPURIOUS_VECTOR |=> rdData == $past(spuriousVector))
      else $error("spurious vector readback mismatch");
   route_view_a: assert property (
      rd && a == OFS_FAST_ROUTE_STATUS |=> rdData == $past(fastRoute))
      else $error("fast route status mismatch");

   service_c: cover property (takeService ##[1:20] eosWr);
   fast_c: cover property (fastActive ##1 !fastRequestLine_b ##1 fvrRd);
   spurious_c: cover property (ivrRd && !normalActive);
   routed_c: cover property (fastActive && !pending[0]);
   masked_c: cover property (globalLineMask && normalActive);
endmodule
`default_nettype wire

/* rtl/vic_pkg.sv */
/*
 * Package of the vectored interrupt controller register block: register offsets, field
 * positions, reset values, bus carrier and service states.
 * Assumes a 4-Kbyte window with byte addresses and one 32-bit word per register.
 */
`default_nettype none
package vic_pkg;
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam int NUM_SRC = 32;
   localparam int ID_W = 5;
   // ****************************
   // register offsets
   // ****************************
   localparam logic [ADDR_W-1:0] OFS_VECTOR_BASE = 12'h080;
   localparam logic [ADDR_W-1:0] OFS_VECTOR_LAST = 12'h0FC;
   localparam logic [ADDR_W-1:0] OFS_NORMAL_VECTOR_READOUT = 12'h100;
   localparam logic [ADDR_W-1:0] OFS_FAST_VECTOR_READOUT = 12'h104;
   localparam logic [ADDR_W-1:0] OFS_CURRENT_SOURCE_STATUS = 12'h108;
   localparam logic [ADDR_W-1:0] OFS_PENDING_VIEW = 12'h10C;
   localparam logic [ADDR_W-1:0] OFS_ENABLE_MASK_VIEW = 12'h110;
   localparam logic [ADDR_W-1:0] OFS_CORE_LINE_STATUS = 12'h114;
   localparam logic [ADDR_W-1:0] OFS_ENABLE_COMMAND = 12'h120;
   localparam logic [ADDR_W-1:0] OFS_DISABLE_COMMAND = 12'h124;
   localparam logic [ADDR_W-1:0] OFS_PENDING_CLEAR_COMMAND = 12'h128;
   localparam logic [ADDR_W-1:0] OFS_PENDING_SET_COMMAND = 12'h12C;
   localparam logic [ADDR_W-1:0] OFS_END_OF_SERVICE_COMMAND = 12'h130;
   localparam logic [ADDR_W-1:0] OFS_SPURIOUS_VECTOR = 12'h134;
   localparam logic [ADDR_W-1:0] OFS_DEBUG_CONTROL = 12'h138;
   localparam logic [ADDR_W-1:0] OFS_FAST_ROUTE_ENABLE = 12'h140;
   localparam logic [ADDR_W-1:0] OFS_FAST_ROUTE_DISABLE = 12'h144;
   localparam logic [ADDR_W-1:0] OFS_FAST_ROUTE_STATUS = 12'h148;
   // ****************************
   // fields and reset values
   // ****************************
   localparam int PROTECTION_ENABLE_BIT = 0;
   localparam int GLOBAL_LINE_MASK_BIT = 1;
   localparam int FAST_LINE_STATUS_BIT = 0;
   localparam int NORMAL_LINE_STATUS_BIT = 1;
   localparam logic [DATA_W-1:0] FAST_SOURCE_MASK = 32'h0000_0001;
   localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0000_0000;
   localparam logic [1:0] DEBUG_CONTROL_RESET = 2'h0;
   // ****************************
   // carrier and states
   // ****************************
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } vic_bus_t;
   typedef enum logic [1:0] {
      SVC_IDLE = 2'b01,
      SVC_BUSY = 2'b10
   } vic_svc_t;
endpackage
`default_nettype wire

/* bench/vic_src_model.sv */
/*
 * Far-side model: the peripheral and external interrupt source pins.
 * Assumes the bench asks for a rise by a one-cycle request mask.
 */
`default_nettype none
module vic_src_model (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // stimulus control
   input wire logic [31:0] raiseReq,
   input wire logic [7:0] holdCycles,
   // source pins
   output logic [31:0] srcIn
);
   timeunit 1ns;
   timeprecision 1ps;
   // ****************************
   // pin levels
   // ****************************
   logic [7:0] holdCnt;
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         srcIn <= '0;
         holdCnt <= '0;
      end else if (raiseReq != '0) begin
         srcIn <= srcIn | raiseReq;
         holdCnt <= holdCycles;
      end else if (holdCnt != '0) begin
         holdCnt <= holdCnt - 8'h01;
      end else begin
         srcIn <= '0;
      end
   end
endmodule
`default_nettype wire

/* bench/vic_regs_bench.sv */
/*
 * Self-checking bench of the interrupt controller register block.
 * Assumes the source model on the pins and a strobe bus driven from here.
 */
`default_nettype none
module vic_regs_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import vic_pkg::*;
   // ****************************
   // signals and instances
   // ****************************
   logic clk_sys, rst_b, fastLine_b, normLine_b, wake;
   vic_bus_t bus;
   logic [DATA_W-1:0] rdData;
   logic [NUM_SRC-1:0] srcIn, raiseReq;
   int fail_count, n_tests;
   int unsigned mdlMask, mdlPend, mdlSpu, mdlFfr, r;
   int unsigned vec[NUM_SRC];
   vic_regs uut (.clk_sys(clk_sys), .rst_b(rst_b), .busIn(bus), .rdData(rdData),
      .srcIn(srcIn), .fastRequestLine_b(fastLine_b), .normalRequestLine_b(normLine_b),
      .wakeRequest(wake));
   vic_src_model srcs (.clk_sys(clk_sys), .rst_b(rst_b), .raiseReq(raiseReq),
      .holdCycles(8'h06), .srcIn(srcIn));
   // ****************************
   // tasks
   // ****************************
   task automatic finish_test();
      if (fail_count == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      bus.addr <= a;
      bus.wdata <= d;
      bus.wr <= 1'h1;
      @(posedge clk_sys);
      bus.wr <= 1'h0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string what);
      @(posedge clk_sys);
      bus.addr <= a;
      bus.rd <= 1'h1;
      @(posedge clk_sys);
      bus.rd <= 1'h0;
      #1;
      chk(what, rdData, exp);
   endtask
   task automatic wait_low(input logic fast);
      for (int k = 0; k < 40; k++) begin
         @(posedge clk_sys);
         #1;
         if ((fast ? fastLine_b : normLine_b) === 1'h0) return;
      end
      fail_count++;
      finish_test();
   endtask
   task automatic raise(input logic [31:0] m);
      @(posedge clk_sys);
      raiseReq <= m;
      @(posedge clk_sys);
      raiseReq <= '0;
   endtask
   // ****************************
   // clock and sequence
   // ****************************
   initial begin
      clk_sys = 1'h0;
      forever #4 clk_sys = ~clk_sys;
   end
   initial begin
      logic [11:0] zr[9];
      zr = '{12'h104, 12'h108, 12'h10C, 12'h110, 12'h114, 12'h134, 12'h138, 12'h148, 12'h118};
      rst_b = 1'h0;
      bus = '0;
      raiseReq = '0;
      fail_count = 0;
      n_tests = 0;
      void'($urandom(97671));
      repeat (2) @(posedge clk_sys);
      rst_b <= 1'h1;
      foreach (zr[i]) rd(zr[i], 32'h0, "reset value");
      for (int i = 0; i < NUM_SRC; i++) begin
         vec[i] = $urandom;
         wr(OFS_VECTOR_BASE + 12'(4 * i), vec[i]);
      end
      mdlSpu = $urandom;
      wr(OFS_SPURIOUS_VECTOR, mdlSpu);
      rd(OFS_SPURIOUS_VECTOR, mdlSpu, "spurious vector");
      wr(OFS_PENDING_VIEW, 32'hFFFFFFFF);
      r = $urandom | 32'h1;
      wr(OFS_FAST_ROUTE_ENABLE, r);
      mdlFfr = r & 32'hFFFFFFFE;
      rd(OFS_FAST_ROUTE_STATUS, mdlFfr, "route after enable");
      r = $urandom;
      wr(OFS_FAST_ROUTE_DISABLE, r);
      mdlFfr &= ~r;
      rd(OFS_FAST_ROUTE_STATUS, mdlFfr, "route after disable");
      wr(OFS_FAST_ROUTE_DISABLE, 32'hFFFFFFFF);
      for (int n = 0; n < 4; n++) begin
         r = $urandom;
         wr(OFS_ENABLE_COMMAND, r);
         mdlMask |= r;
         rd(OFS_ENABLE_MASK_VIEW, mdlMask, "mask after enable");
         r = $urandom;
         wr(OFS_DISABLE_COMMAND, r);
         mdlMask &= ~r;
         rd(OFS_ENABLE_MASK_VIEW, mdlMask, "mask after disable");
      end
      wr(OFS_DISABLE_COMMAND, 32'hFFFFFFFF);
      mdlPend = 0;
      for (int n = 0; n < 4; n++) begin
         r = $urandom;
         wr(OFS_PENDING_SET_COMMAND, r);
         mdlPend |= r;
         rd(OFS_PENDING_VIEW, mdlPend, "pending after set");
         r = $urandom;
         wr(OFS_PENDING_CLEAR_COMMAND, r);
         mdlPend &= ~r;
         rd(OFS_PENDING_VIEW, mdlPend, "pending after clear");
      end
      wr(OFS_PENDING_CLEAR_COMMAND, 32'hFFFFFFFF);
      // pin-driven normal service of source 5
      wr(OFS_ENABLE_COMMAND, 32'h20);
      raise(32'h20);
      wait_low(1'h0);
      rd(OFS_CORE_LINE_STATUS, 32'h2, "line status");
      rd(OFS_NORMAL_VECTOR_READOUT, vec[5], "normal vector");
      rd(OFS_CURRENT_SOURCE_STATUS, 32'h5, "current source");
      rd(OFS_PENDING_VIEW, 32'h0, "pending after ack");
      wr(OFS_END_OF_SERVICE_COMMAND, $urandom);
      rd(OFS_NORMAL_VECTOR_READOUT, mdlSpu, "idle normal vector");
      // fast source, then nothing left
      wr(OFS_ENABLE_COMMAND, 32'h1);
      wr(OFS_PENDING_SET_COMMAND, 32'h1);
      wait_low(1'h1);
      rd(OFS_FAST_VECTOR_READOUT, vec[0], "fast vector");
      rd(OFS_FAST_VECTOR_READOUT, mdlSpu, "idle fast vector");
      // global line mask
      wr(OFS_DEBUG_CONTROL, 32'h2);
      rd(OFS_DEBUG_CONTROL, 32'h2, "debug control");
      wr(OFS_ENABLE_COMMAND, 32'h80);
      wr(OFS_PENDING_SET_COMMAND, 32'h80);
      repeat (6) @(posedge clk_sys);
      #1;
      chk("masked lines", {30'h0, fastLine_b, normLine_b}, 32'h3);
      chk("wake", {31'h0, wake}, 32'h1);
      wr(OFS_DEBUG_CONTROL, 32'h0);
      wait_low(1'h0);
      rd(OFS_NORMAL_VECTOR_READOUT, vec[7], "normal vector 7");
      wr(OFS_END_OF_SERVICE_COMMAND, 32'h0);
      // protection mode
      wr(OFS_DEBUG_CONTROL, 32'h1);
      rd(OFS_DEBUG_CONTROL, 32'h1, "protection on");
      wr(OFS_PENDING_SET_COMMAND, 32'h8);
      wr(OFS_ENABLE_COMMAND, 32'h8);
      wait_low(1'h0);
      rd(OFS_NORMAL_VECTOR_READOUT, vec[3], "protected vector");
      rd(OFS_PENDING_VIEW, 32'h8, "pending kept");
      wr(OFS_NORMAL_VECTOR_READOUT, 32'h0);
      rd(OFS_CURRENT_SOURCE_STATUS, 32'h3, "protected ack");
      rd(OFS_PENDING_VIEW, 32'h0, "pending after write ack");
      wr(OFS_END_OF_SERVICE_COMMAND, 32'h0);
      // peripheral source 9 routed to the fast path, then back to normal
      wr(OFS_DEBUG_CONTROL, 32'h0);
      wr(OFS_FAST_ROUTE_ENABLE, 32'h200);
      wr(OFS_ENABLE_COMMAND, 32'h200);
      wr(OFS_PENDING_SET_COMMAND, 32'h200);
      wait_low(1'h1);
      rd(OFS_CORE_LINE_STATUS, 32'h1, "routed line status");
      rd(OFS_FAST_VECTOR_READOUT, vec[0], "routed fast vector");
      rd(OFS_PENDING_VIEW, 32'h200, "routed pending kept");
      wr(OFS_FAST_ROUTE_DISABLE, 32'h200);
      wait_low(1'h0);
      rd(OFS_NORMAL_VECTOR_READOUT, vec[9], "unrouted vector");
      rd(OFS_CURRENT_SOURCE_STATUS, 32'h9, "unrouted source");
      wr(OFS_END_OF_SERVICE_COMMAND, 32'h0);
      finish_test();
   end
endmodule
`default_nettype wire
